//--- ist_i2c_master.sv
// behavioural I2C master that reads bytes from the slave
`timescale 1ns/100ps
`default_nettype none
module ist_i2c_master
(
   // clock
   input  wire logic i_clk,
   // resolved wire levels
   input  wire logic i_scl,
   input  wire logic i_sda,
   // open-drain drive, 1 = released
   output logic      o_scl,
   output logic      o_sda
);
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   task automatic half();
      repeat (4) @(posedge i_clk);
   endtask

   // sda moves one clock after scl falls so no false start or stop is seen
   task automatic bit_io(input logic b, output logic r);
      int n;
      @(posedge i_clk);
      o_sda <= b;
      repeat (3) @(posedge i_clk);
      o_scl <= 1'b1;
      n = 0;
      // the slave may stretch the low phase
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (!i_scl && n < 4000);
      repeat (3) @(posedge i_clk);
      r = i_sda;
      o_scl <= 1'b0;
   endtask

   task automatic start();
      @(posedge i_clk);
      o_sda <= 1'b1;
      o_scl <= 1'b1;
      half();
      o_sda <= 1'b0;
      half();
      o_scl <= 1'b0;
   endtask

   task automatic stop();
      @(posedge i_clk);
      o_sda <= 1'b0;
      half();
      o_scl <= 1'b1;
      half();
      o_sda <= 1'b1;
      half();
   endtask

   task automatic put_byte(input logic [7:0] b, output logic r);
      logic x;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], x);
      bit_io(1'b1, r);
   endtask

   // coll pulls the first bit low to force a collision
   task automatic get_byte(input logic coll, input logic nack, output logic [7:0] q);
      logic x;
      for (int i = 7; i >= 0; i--)
         bit_io(!(coll && i == 7), q[i]);
      bit_io(nack, x);
   endtask
endmodule
`default_nettype wire

//--- ist_pkg.sv
// constants and types for the I2C slave transmitter
package ist_pkg;
   // register byte offsets
   localparam logic [7:0] IST_OFS_ADDR = 8'h00;
   localparam logic [7:0] IST_OFS_BUF  = 8'h04;
   localparam logic [7:0] IST_OFS_CTL1 = 8'h08;
   localparam logic [7:0] IST_OFS_CTL2 = 8'h0C;
   localparam logic [7:0] IST_OFS_CTL3 = 8'h10;
   localparam logic [7:0] IST_OFS_MASK = 8'h14;
   localparam logic [7:0] IST_OFS_STAT = 8'h18;
   localparam logic [7:0] IST_OFS_ISTS = 8'h1C;
   localparam logic [7:0] IST_OFS_IMSK = 8'h20;
   // field positions
   localparam int IST_C1_RELEASE  = 4;
   localparam int IST_C1_ENABLE   = 5;
   localparam int IST_C2_ACK_STATUS_BIT  = 6;
   localparam int IST_C3_SLAVE_COLLISION_DETECT_ENABLE    = 2;
   localparam int IST_C3_START_IE = 5;
   localparam int IST_ST_BF       = 0;
   localparam int IST_ST_RW       = 2;
   localparam int IST_ST_START    = 3;
   localparam int IST_ST_STOP     = 4;
   localparam int IST_IRQ_PORT    = 0;
   localparam int IST_IRQ_BCOL    = 1;
   // reset values and counts
   localparam logic [7:0] IST_RST_ADDR = 8'h00;
   localparam logic [7:0] IST_RST_MASK = 8'hFF;
   localparam logic [3:0] IST_ADDR_BITS = 4'h8;
   localparam logic [3:0] IST_LAST_BIT  = 4'h7;

   typedef enum logic [2:0]
   {
      IST_IDLE = 3'b000,
      IST_ADDR = 3'b001,
      IST_AACK = 3'b010,
      IST_TX   = 3'b011,
      IST_MACK = 3'b100
   } ist_state_type;
endpackage

//--- ist_slave_tx.sv
// I2C slave transmitter with APB registers
// Function
// - matched read address sets read/write bit
// - address into buffer, acknowledge ninth bit
// - after address ack clear release, hold SCL
// - buffer write also loads shift register
// - setting release bit frees SCL
// - SDA changes only on falling SCL or on a buffer write
// - master acknowledge sampled on ninth rise
// - not-acknowledge ends transfer, go idle
// - interrupt flag on ninth falling edge
// - collision with detect enabled sets flag
// - after collision go idle
// - start sets start bit, optional interrupt
// - buffer read clears buffer-full bit
// - ack status, collision flag and address shift-in update on rise
// - ack stretches clock, nack does not
// - restart or stop ends addressing
`timescale 1ns/100ps
`default_nettype none
module ist_slave_tx
   import ist_pkg::*;
(
   // clock and reset
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RSTN,
   // APB slave
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   // I2C link, open drain
   input  wire logic        I_SCL,
   output logic             O_SCL,
   output logic             O_SCL_OE_N,
   input  wire logic        I_SDA,
   output logic             O_SDA,
   output logic             O_SDA_OE_N,
   // interrupt
   output logic             O_IRQ
);
   ist_state_type state;
   logic [1:0]  pins;
   logic        scl_s;
   logic        sda_s;
   logic        scl_d;
   logic        sda_d;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic [7:0]  slave_addr;
   logic [7:0]  mask_reg;
   logic [7:0]  buf_reg;
   logic [7:0]  shift;
   logic [3:0]  bit_cnt;
   logic        enable;
   logic        clk_rel;
   logic        slave_collision_detect_enable;
   logic        start_ie;
   logic        ack_status;
   logic        bf;
   logic        rw;
   logic        start_seen;
   logic        stop_seen;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic        addr_match;
   logic        addr_done;
   logic        collision;
   logic        ninth_fall;
   logic [1:0]  irq_set;
   logic [1:0]  irq_clr;
   logic [7:0]  next_rdata;

   ist_sync #(.W(2), .RST_VAL(2'h3)) u_sync
   (
      .i_clk  (I_CORE_CLK),
      .i_rstn (I_RSTN),
      .i_d    ({I_SDA, I_SCL}),
      .o_q    (pins)
   );
   assign scl_s = pins[0];
   assign sda_s = pins[1];

   always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_d;
   assign scl_fall  = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

   // APB decode: zero wait states, read data captured in setup
   assign wr       = I_PSEL & I_PENABLE & I_PWRITE & mapped;
   assign rd       = I_PSEL & I_PENABLE & ~I_PWRITE & mapped;
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;

   always_comb
   begin
      mapped     = 1'b1;
      next_rdata = 8'h00;
      unique case (I_PADDR)
         IST_OFS_ADDR: next_rdata = slave_addr;
         IST_OFS_BUF:  next_rdata = buf_reg;
         IST_OFS_CTL1:
         begin
            next_rdata[IST_C1_RELEASE] = clk_rel;
            next_rdata[IST_C1_ENABLE]  = enable;
         end
         IST_OFS_CTL2: next_rdata[IST_C2_ACK_STATUS_BIT] = ack_status;
         IST_OFS_CTL3:
         begin
            next_rdata[IST_C3_SLAVE_COLLISION_DETECT_ENABLE]    = slave_collision_detect_enable;
            next_rdata[IST_C3_START_IE] = start_ie;
         end
         IST_OFS_MASK: next_rdata = mask_reg;
         IST_OFS_STAT:
         begin
            next_rdata[IST_ST_BF]    = bf;
            next_rdata[IST_ST_RW]    = rw;
            next_rdata[IST_ST_START] = start_seen;
            next_rdata[IST_ST_STOP]  = stop_seen;
         end
         IST_OFS_ISTS: next_rdata[1:0] = irq_status;
         IST_OFS_IMSK: next_rdata[1:0] = irq_mask;
         default:      mapped = 1'b0;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
         O_PRDATA <= 32'h0000_0000;
      else if (I_PSEL & ~I_PENABLE & ~I_PWRITE)
         O_PRDATA <= {24'h00_0000, next_rdata};
   end

   // software configuration
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         slave_addr <= IST_RST_ADDR;
         mask_reg   <= IST_RST_MASK;
         enable     <= 1'b0;
         slave_collision_detect_enable      <= 1'b0;
         start_ie   <= 1'b0;
         irq_mask   <= 2'h0;
      end
      else if (wr)
      begin
         if (I_PADDR == IST_OFS_ADDR)
            slave_addr <= I_PWDATA[7:0];
         if (I_PADDR == IST_OFS_MASK)
            mask_reg <= I_PWDATA[7:0];
         if (I_PADDR == IST_OFS_CTL1)
            enable <= I_PWDATA[IST_C1_ENABLE];
         if (I_PADDR == IST_OFS_CTL3)
         begin
            slave_collision_detect_enable    <= I_PWDATA[IST_C3_SLAVE_COLLISION_DETECT_ENABLE];
            start_ie <= I_PWDATA[IST_C3_START_IE];
         end
         if (I_PADDR == IST_OFS_IMSK)
            irq_mask <= I_PWDATA[1:0];
      end
   end

   assign addr_match = ((shift[7:1] ^ slave_addr[7:1]) & mask_reg[7:1]) == 7'h00;
   assign addr_done  = (state == IST_ADDR) & scl_fall & (bit_cnt == IST_ADDR_BITS);
   // released high bit read back low
   assign collision  = (state == IST_TX) & scl_rise & shift[7] & ~sda_s & slave_collision_detect_enable;
   assign ninth_fall = scl_fall & ((state == IST_AACK) | (state == IST_MACK));

   // transfer sequencer and output shift register
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         state   <= IST_IDLE;
         shift   <= 8'h00;
         bit_cnt <= 4'h0;
      end
      else
      begin
         if (!enable)
            state <= IST_IDLE;
         // restart re-arms address phase, stop drops out
         else if (start_det)
         begin
            state   <= IST_ADDR;
            bit_cnt <= 4'h0;
         end
         else if (stop_det)
            state <= IST_IDLE;
         else
         begin
            unique case (state)
               IST_IDLE: ;
               IST_ADDR:
               begin
                  if (scl_rise)
                  begin
                     shift   <= {shift[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  // write direction belongs to the receiver, not here
                  if (addr_done)
                     state <= (addr_match & shift[0]) ? IST_AACK : IST_IDLE;
               end
               IST_AACK:
                  if (scl_fall)
                  begin
                     state   <= IST_TX;
                     bit_cnt <= 4'h0;
                  end
               IST_TX:
               begin
                  if (collision)
                     state <= IST_IDLE;
                  // next bit presented after falling edge
                  else if (scl_fall)
                  begin
                     shift   <= {shift[6:0], 1'b1};
                     bit_cnt <= bit_cnt + 4'h1;
                     if (bit_cnt == IST_LAST_BIT)
                        state <= IST_MACK;
                  end
               end
               IST_MACK:
                  if (scl_fall)
                  begin
                     state   <= ack_status ? IST_IDLE : IST_TX;
                     bit_cnt <= 4'h0;
                  end
               default: state <= IST_IDLE;
            endcase
         end
         if (wr && (I_PADDR == IST_OFS_BUF))
            shift <= I_PWDATA[7:0];
      end
   end

   // master acknowledge taken on the ninth rise
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
         ack_status <= 1'b0;
      else if ((state == IST_MACK) && scl_rise)
         ack_status <= sda_s;
   end

   // transfer buffer and buffer-full flag
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         buf_reg <= 8'h00;
         bf      <= 1'b0;
      end
      else
      begin
         // reading the buffer frees it
         if (rd && (I_PADDR == IST_OFS_BUF))
            bf <= 1'b0;
         if (wr && (I_PADDR == IST_OFS_BUF))
            buf_reg <= I_PWDATA[7:0];
         // matched address lands in buffer; set wins
         if (addr_done && addr_match && shift[0])
         begin
            buf_reg <= shift;
            bf      <= 1'b1;
         end
      end
   end

   // bus status bits; all move on falling edges or start/stop
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         rw         <= 1'b0;
         start_seen <= 1'b0;
         stop_seen  <= 1'b0;
      end
      else
      begin
         if (start_det)
         begin
            start_seen <= 1'b1;
            stop_seen  <= 1'b0;
            rw         <= 1'b0;
         end
         if (stop_det)
         begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b1;
            rw         <= 1'b0;
         end
         if (addr_done && addr_match && shift[0])
            rw <= 1'b1;
      end
   end

   // clock release: hardware clear beats a same-cycle software write
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
         clk_rel <= 1'b1;
      // stretch after address ack; and after master ack
      else if (scl_fall && ((state == IST_AACK) || ((state == IST_MACK) && !ack_status)))
         clk_rel <= 1'b0;
      else if (wr && (I_PADDR == IST_OFS_CTL1))
         clk_rel <= I_PWDATA[IST_C1_RELEASE];
   end

   // interrupt status, write one to clear, set wins
   always_comb
   begin
      irq_set = 2'h0;
      irq_clr = 2'h0;
      // one flag per byte on ninth fall; start if enabled
      irq_set[IST_IRQ_PORT] = ninth_fall | (start_det & start_ie & enable);
      irq_set[IST_IRQ_BCOL] = collision;
      if (wr && (I_PADDR == IST_OFS_ISTS))
         irq_clr = I_PWDATA[1:0];
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         irq_status <= 2'h0;
         O_IRQ      <= 1'b0;
      end
      else
      begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
         O_IRQ      <= |(irq_status & irq_mask);
      end
   end

   // open-drain drivers; registered so the pins never glitch
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         O_SDA_OE_N <= 1'b1;
         O_SCL_OE_N <= 1'b1;
      end
      else
      begin
         O_SDA_OE_N <= ~((state == IST_AACK) | ((state == IST_TX) & ~shift[7]));
         // hold SCL low in the transmit state while release bit is clear
         O_SCL_OE_N <= ~((state == IST_TX) & ~clk_rel);
      end
   end
   assign O_SDA = 1'b0;
   assign O_SCL = 1'b0;

   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RSTN);

   property p_rw_set;
      addr_done && addr_match && shift[0] && enable && !start_det && !stop_det |=> rw;
   endproperty
   a_rw_set: assert property (p_rw_set) else $error("rw not set");

   property p_addr_buf;
      addr_done && addr_match && shift[0] |=> bf && buf_reg == $past(shift);
   endproperty
   a_addr_buf: assert property (p_addr_buf) else $error("address not buffered");

   property p_stretch;
      enable && state == IST_AACK && scl_fall && !start_det && !stop_det
      |=> !clk_rel && state == IST_TX ##1 !O_SCL_OE_N;
   endproperty
   a_stretch: assert property (p_stretch) else $error("no stretch");

   property p_buf_load;
      wr && I_PADDR == IST_OFS_BUF |=> shift == $past(I_PWDATA[7:0]);
   endproperty
   a_buf_load: assert property (p_buf_load) else $error("shift not loaded");

   property p_release;
      state == IST_TX && clk_rel |=> O_SCL_OE_N;
   endproperty
   a_release: assert property (p_release) else $error("SCL still held");

   property p_sda_fall;
      state == IST_TX && $past(state) == IST_TX && $changed(shift)
      && !$past(wr) |-> $past(scl_fall);
   endproperty
   a_sda_fall: assert property (p_sda_fall) else $error("bit moved off fall");

   property p_ack_rise;
      state == IST_MACK && scl_rise |=> ack_status == $past(sda_s);
   endproperty
   a_ack_rise: assert property (p_ack_rise) else $error("ack not latched");

   property p_nack_idle;
      enable && state == IST_MACK && scl_fall && ack_status && !start_det
      |=> state == IST_IDLE ##1 O_SCL_OE_N;
   endproperty
   a_nack_idle: assert property (p_nack_idle) else $error("nack not idle");

   property p_ninth_irq;
      ninth_fall |=> irq_status[IST_IRQ_PORT];
   endproperty
   a_ninth_irq: assert property (p_ninth_irq) else $error("no byte flag");

   property p_bcol;
      collision && enable && !start_det && !stop_det
      |=> irq_status[IST_IRQ_BCOL] && state == IST_IDLE;
   endproperty
   a_bcol: assert property (p_bcol) else $error("collision missed");

   property p_start;
      start_det |=> start_seen && !stop_seen;
   endproperty
   a_start: assert property (p_start) else $error("start bit missing");

   property p_bf_clr;
      rd && I_PADDR == IST_OFS_BUF && !(addr_done && addr_match && shift[0]) |=> !bf;
   endproperty
   a_bf_clr: assert property (p_bf_clr) else $error("bf not cleared");
endmodule
`default_nettype wire

//--- ist_slave_tx_tb_top.sv
// self-checking bench for the I2C slave transmitter
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: %h expected %h", $time, g, e); end end
module ist_slave_tx_tb_top;
   import ist_pkg::*;
   logic        clk;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         scl_d;
   wire         scl_oe_n;
   wire         sda_d;
   wire         sda_oe_n;
   wire         irq;
   wire         m_scl;
   wire         m_sda;
   wire         scl_w;
   wire         sda_w;
   logic        err;
   logic        got_v;
   logic [31:0] got;
   logic [31:0] e;
   logic [31:0] exp_q[$];
   logic [31:0] seed;
   logic [6:0]  addr;
   int          fail_count;
   int          tests_run;

   // pull-ups on both lines
   assign scl_w = m_scl & (scl_oe_n | scl_d);
   assign sda_w = m_sda & (sda_oe_n | sda_d);

   ist_slave_tx ist_slave_tx_inst (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCL(scl_w),
      .O_SCL(scl_d), .O_SCL_OE_N(scl_oe_n), .I_SDA(sda_w), .O_SDA(sda_d),
      .O_SDA_OE_N(sda_oe_n), .O_IRQ(irq));
   ist_i2c_master ist_i2c_master_inst (.i_clk(clk), .i_scl(scl_w), .i_sda(sda_w),
      .o_scl(m_scl), .o_sda(m_sda));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk)
      if (got_v && exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         `CHK(got, e)
      end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic end_of_test();
      if (fail_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!pready && n < 100);
      // a slave that never answers counts against the run
      if (!pready)
         fail_count++;
      r   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] v, input logic [31:0] x);
      exp_q.push_back(x);
      got   <= v;
      got_v <= 1'b1;
      @(posedge clk);
      got_v <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r & m, x & m);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask

   task automatic xfer(input logic [6:0] a, input int n, input logic coll);
      logic [7:0] d;
      logic [7:0] q;
      logic       r;
      ist_i2c_master_inst.start();
      repeat (8) @(posedge clk);
      rd(IST_OFS_STAT, 32'h08, 32'h08);
      rd(IST_OFS_ISTS, 32'h01, 32'h01);
      wr(IST_OFS_ISTS, 32'h01);
      ist_i2c_master_inst.put_byte({a, 1'b1}, r);
      chk({31'h0, r}, {31'h0, a != addr});
      if (a == addr)
      begin
         repeat (8) @(posedge clk);
         chk({31'h0, scl_oe_n}, 32'h0);
         rd(IST_OFS_STAT, 32'h05, 32'h05);
         rd(IST_OFS_ISTS, 32'h01, 32'h01);
         rd(IST_OFS_CTL1, 32'h10, 32'h00);
         rd(IST_OFS_BUF, 32'hFF, {24'h0, a, 1'b1});
         rd(IST_OFS_STAT, 32'h01, 32'h00);
         for (int i = 0; i < n; i++)
         begin
            d = 8'(rnd());
            d[7] = d[7] | coll;
            wr(IST_OFS_BUF, {24'h0, d});
            wr(IST_OFS_ISTS, 32'h01);
            wr(IST_OFS_CTL1, 32'h30);
            ist_i2c_master_inst.get_byte(coll, i == n - 1, q);
            repeat (8) @(posedge clk);
            if (coll)
            begin
               rd(IST_OFS_ISTS, 32'h02, 32'h02);
               chk({31'h0, sda_oe_n}, 32'h1);
               wr(IST_OFS_IMSK, 32'h00);
               repeat (3) @(posedge clk);
               chk({31'h0, irq}, 32'h0);
               wr(IST_OFS_IMSK, 32'h02);
               repeat (3) @(posedge clk);
               chk({31'h0, irq}, 32'h1);
               wr(IST_OFS_ISTS, 32'h02);
               repeat (3) @(posedge clk);
               chk({31'h0, irq}, 32'h0);
               wr(IST_OFS_IMSK, 32'h03);
            end
            else
            begin
               chk({24'h0, q}, {24'h0, d});
               chk({31'h0, scl_oe_n}, {31'h0, i == n - 1});
               rd(IST_OFS_CTL2, 32'h40, (i == n - 1) ? 32'h40 : 32'h0);
               rd(IST_OFS_ISTS, 32'h01, 32'h01);
            end
         end
      end
      ist_i2c_master_inst.stop();
      repeat (8) @(posedge clk);
      rd(IST_OFS_STAT, 32'h1C, 32'h10);
      wr(IST_OFS_ISTS, 32'h03);
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      end_of_test();
   end

   initial
   begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      got_v = 1'b0;
      got = 32'h0;
      fail_count = 0;
      tests_run = 0;
      seed = 32'h0000000A;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      rd(IST_OFS_CTL1, 32'h30, 32'h10);
      rd(IST_OFS_MASK, 32'hFF, 32'hFF);
      rd(8'h24, 32'hFFFFFFFF, 32'h0);
      chk({31'h0, err}, 32'h1);
      addr = 7'(rnd());
      wr(IST_OFS_ADDR, {24'h0, addr, 1'b0});
      wr(IST_OFS_IMSK, 32'h03);
      wr(IST_OFS_CTL3, 32'h24);
      wr(IST_OFS_CTL1, 32'h30);
      xfer(addr, 2, 1'b0);
      xfer(addr ^ 7'h01, 0, 1'b0);
      xfer(addr, 1, 1'b1);
      xfer(addr, 1, 1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire

//--- ist_sync.sv
// two-flop synchroniser for the link pins
`timescale 1ns/100ps
`default_nettype none
module ist_sync
#(
   parameter int         W       = 2,
   parameter logic [1:0] RST_VAL = 2'h3
)
(
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rstn,
   // pins in, synchronised out
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta;

   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         always_ff @(posedge i_clk or negedge i_rstn)
         begin
            if (!i_rstn)
            begin
               meta[g] <= RST_VAL[g];
               o_q[g]  <= RST_VAL[g];
            end
            else
            begin
               meta[g] <= i_d[g];
               o_q[g]  <= meta[g];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire
